// File: rtl/avifr_readout.v
// Our own choice: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "avifr_defines.vh"

// What this block does
// - Bar info is a 2-bit code: 01 horizontal, 10 vertical, 11 both.
// - Scan info sits in bits 1:0: 00 none, 01 overscan, 10 underscan.
// - Bits 7:6 at 0x82 hold colorimetry: 00 none, 01 601, 10 709.
// - Bits 5:4 at 0x82 hold picture aspect, bits 3:0 active aspect.
// - Bits 1:0 at 0x83 report the non-uniform scaling code.
// - Bits 6:0 at 0x84 present the received video format code.
// - Bits 3:0 at 0x85 present the pixel repetition count.
// - New-data flags set on content change, bit 0 for this frame,
//         and any read of a flag register clears them all.
// - Bits 6:5 of 0x81 report colour format: 00 RGB, 01 422, 10 444.
module avifr_readout (
  input  wire        clk_i,
  input  wire        rst_i,
  // Decoded frame from the parser, one-cycle strobe
  input  wire        frame_valid_i,
  input  wire [1:0]  colour_format_i,
  input  wire [1:0]  bar_info_i,
  input  wire [1:0]  scan_info_i,
  input  wire [1:0]  colorimetry_i,
  input  wire [1:0]  picture_aspect_i,
  input  wire [3:0]  active_aspect_i,
  input  wire [1:0]  nonuniform_scaling_code_i,
  input  wire [6:0]  video_format_code_i,
  input  wire [3:0]  pixel_repetition_count_i,
  // Change strobes of the other packet kinds, bits 6:1 of the flags
  input  wire [5:0]  other_change_i,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [31:0] wb_dat_i,
  input  wire [3:0]  wb_sel_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  output reg         wb_err_o,
  output reg         irq_o
);

  wire [7:0] fmt_info_q;
  wire [7:0] colour_and_aspect_info_q;
  wire [7:0] scaling_info_q;
  wire [7:0] video_format_code_q;
  wire [7:0] pixel_repetition_q;
  wire [4:0] chg;
  wire       avi_changed;

  reg  [6:0] new_data_flag_reg;
  reg  [6:0] new_data_flag_next;
  reg  [1:0] irq_status_reg;
  reg  [1:0] irq_status_next;
  reg  [1:0] irq_mask_reg;
  reg  [1:0] irq_mask_next;
  reg        frame_seen_reg;
  reg  [31:0] rdata;
  reg        hit;
  // Register words before storage
  reg  [7:0] fmt_word;
  reg  [7:0] colour_word;
  reg  [7:0] scaling_word;
  reg  [7:0] vfc_word;
  reg  [7:0] pixrep_word;
  // Register selects
  reg        sel_fmt;
  reg        sel_colour;
  reg        sel_scaling;
  reg        sel_vfc;
  reg        sel_pixrep;
  reg        sel_flags;
  reg        sel_status;
  reg        sel_mask;
  // Bus strobes
  wire       req;
  wire       rd_stb;
  wire       wr_stb;
  wire       rd_flags;
  wire       wr_status;
  wire       wr_mask;

  // Fields at their bit positions; spare bits read zero
  always @* begin
    fmt_word     = `AVIFR_FIELD_RST;
    colour_word  = `AVIFR_FIELD_RST;
    scaling_word = `AVIFR_FIELD_RST;
    vfc_word     = `AVIFR_FIELD_RST;
    pixrep_word  = `AVIFR_FIELD_RST;
    fmt_word[`AVIFR_CFMT_MSB:`AVIFR_CFMT_LSB] = colour_format_i;
    fmt_word[`AVIFR_BAR_MSB:`AVIFR_BAR_LSB] = bar_info_i;
    fmt_word[`AVIFR_SCAN_MSB:`AVIFR_SCAN_LSB] = scan_info_i;
    colour_word[`AVIFR_COLORIM_MSB:`AVIFR_COLORIM_LSB] = colorimetry_i;
    colour_word[`AVIFR_PICASP_MSB:`AVIFR_PICASP_LSB] = picture_aspect_i;
    colour_word[`AVIFR_AFASP_MSB:`AVIFR_AFASP_LSB] = active_aspect_i;
    scaling_word[`AVIFR_NUS_MSB:`AVIFR_NUS_LSB] = nonuniform_scaling_code_i;
    vfc_word[`AVIFR_VFC_MSB:`AVIFR_VFC_LSB] = video_format_code_i;
    pixrep_word[`AVIFR_PRC_MSB:`AVIFR_PRC_LSB] = pixel_repetition_count_i;
  end

  // Bus writes never reach these loads
  // load per frame
  avifr_field_reg #(.WIDTH(8)) u_fmt (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .load_i    (frame_valid_i),
    .data_i    (fmt_word),
    .q_o       (fmt_info_q),
    .changed_o (chg[0])
  );

  avifr_field_reg #(.WIDTH(8)) u_colour (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .load_i    (frame_valid_i),
    .data_i    (colour_word),
    .q_o       (colour_and_aspect_info_q),
    .changed_o (chg[1])
  );

  avifr_field_reg #(.WIDTH(8)) u_scaling (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .load_i    (frame_valid_i),
    .data_i    (scaling_word),
    .q_o       (scaling_info_q),
    .changed_o (chg[2])
  );

  avifr_field_reg #(.WIDTH(8)) u_vfc (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .load_i    (frame_valid_i),
    .data_i    (vfc_word),
    .q_o       (video_format_code_q),
    .changed_o (chg[3])
  );

  avifr_field_reg #(.WIDTH(8)) u_pixrep (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .load_i    (frame_valid_i),
    .data_i    (pixrep_word),
    .q_o       (pixel_repetition_q),
    .changed_o (chg[4])
  );

  assign avi_changed = |chg;

  // Classic Wishbone, one request per ack
  assign req    = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign rd_stb = req && !wb_we_i && hit;
  assign wr_stb = req && wb_we_i && hit;

  // One select per register; unmapped offsets answer with err
  always @* begin
    sel_fmt     = 1'b0;
    sel_colour  = 1'b0;
    sel_scaling = 1'b0;
    sel_vfc     = 1'b0;
    sel_pixrep  = 1'b0;
    sel_flags   = 1'b0;
    sel_status  = 1'b0;
    sel_mask    = 1'b0;
    hit         = 1'b1;
    if (wb_adr_i == `AVIFR_OFF_FMT_INFO) begin
      sel_fmt = 1'b1;
    end else if (wb_adr_i == `AVIFR_OFF_COLOUR) begin
      sel_colour = 1'b1;
    end else if (wb_adr_i == `AVIFR_OFF_SCALING) begin
      sel_scaling = 1'b1;
    end else if (wb_adr_i == `AVIFR_OFF_VFC) begin
      sel_vfc = 1'b1;
    end else if (wb_adr_i == `AVIFR_OFF_PIXREP) begin
      sel_pixrep = 1'b1;
    end else if (wb_adr_i == `AVIFR_OFF_FLAGS_A ||
                 wb_adr_i == `AVIFR_OFF_FLAGS_B) begin
      sel_flags = 1'b1;
    end else if (wb_adr_i == `AVIFR_OFF_IRQ_STATUS) begin
      sel_status = 1'b1;
    end else if (wb_adr_i == `AVIFR_OFF_IRQ_MASK) begin
      sel_mask = 1'b1;
    end else begin
      hit = 1'b0;
    end
  end

  // Read mux over stored copies, never the live parser inputs
  always @* begin
    rdata = 32'h00000000;
    if (sel_fmt) begin
      rdata = {24'h000000, fmt_info_q};
    end else if (sel_colour) begin
      rdata = {24'h000000, colour_and_aspect_info_q};
    end else if (sel_scaling) begin
      rdata = {24'h000000, scaling_info_q};
    end else if (sel_vfc) begin
      rdata = {24'h000000, video_format_code_q};
    end else if (sel_pixrep) begin
      rdata = {24'h000000, pixel_repetition_q};
    end else if (sel_flags) begin
      rdata = {25'h0, new_data_flag_reg};
    end else if (sel_status) begin
      rdata = {30'h0, irq_status_reg};
    end else if (sel_mask) begin
      rdata = {30'h0, irq_mask_reg};
    end
  end

  // Only the low byte lane carries writable bits
  assign rd_flags  = rd_stb && sel_flags;
  assign wr_status = wr_stb && wb_sel_i[0] && sel_status;
  assign wr_mask   = wr_stb && wb_sel_i[0] && sel_mask;

  // Flag next state
  always @* begin
    new_data_flag_next = new_data_flag_reg;
    if (rd_flags) begin
      new_data_flag_next = `AVIFR_FLAG_RST;
    end
    // set on change
    // Set after clear so a same-cycle change is not lost
    new_data_flag_next = new_data_flag_next |
                         {other_change_i, avi_changed};
  end

  // Status and mask next state; a set beats a same-cycle clear
  always @* begin
    irq_status_next = irq_status_reg;
    if (wr_status) begin
      irq_status_next = irq_status_reg & ~wb_dat_i[1:0];
    end
    irq_status_next[`AVIFR_IRQ_FRAME_BIT] =
      irq_status_next[`AVIFR_IRQ_FRAME_BIT] | frame_seen_reg;
    irq_status_next[`AVIFR_IRQ_CHANGE_BIT] =
      irq_status_next[`AVIFR_IRQ_CHANGE_BIT] | avi_changed;
    irq_mask_next = irq_mask_reg;
    if (wr_mask) begin
      irq_mask_next = wb_dat_i[1:0];
    end
  end

  // Flag, status and mask storage
  always @(posedge clk_i) begin
    if (rst_i) begin
      new_data_flag_reg <= `AVIFR_FLAG_RST;
      irq_status_reg    <= `AVIFR_IRQ_RST;
      irq_mask_reg      <= `AVIFR_IRQ_RST;
      frame_seen_reg    <= 1'b0;
    end else begin
      new_data_flag_reg <= new_data_flag_next;
      irq_status_reg    <= irq_status_next;
      irq_mask_reg      <= irq_mask_next;
      // Aligns frame event with field update
      frame_seen_reg    <= frame_valid_i;
    end
  end

  // Bus answer one cycle after the request is taken
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req && hit;
      // Unmapped address answers with err
      wb_err_o <= req && !hit;
      wb_dat_o <= (req && hit && !wb_we_i) ? rdata : 32'h00000000;
    end
  end

  // Built from next state so the level does not lag status
  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_status_next & irq_mask_next);
    end
  end

endmodule // avifr_readout

`default_nettype wire

// File: shared/avifr_defines.vh
`ifndef AVIFR_DEFINES_VH
`define AVIFR_DEFINES_VH

// Byte offsets on the bus
`define AVIFR_OFF_FMT_INFO    8'h81
`define AVIFR_OFF_COLOUR      8'h82
`define AVIFR_OFF_SCALING     8'h83
`define AVIFR_OFF_VFC         8'h84
`define AVIFR_OFF_PIXREP      8'h85
`define AVIFR_OFF_FLAGS_A     8'h87
`define AVIFR_OFF_FLAGS_B     8'h8F
`define AVIFR_OFF_IRQ_STATUS  8'hF0
`define AVIFR_OFF_IRQ_MASK    8'hF4

// Field positions
`define AVIFR_CFMT_MSB        6
`define AVIFR_CFMT_LSB        5
`define AVIFR_BAR_MSB         3
`define AVIFR_BAR_LSB         2
`define AVIFR_SCAN_MSB        1
`define AVIFR_SCAN_LSB        0
`define AVIFR_COLORIM_MSB     7
`define AVIFR_COLORIM_LSB     6
`define AVIFR_PICASP_MSB      5
`define AVIFR_PICASP_LSB      4
`define AVIFR_AFASP_MSB       3
`define AVIFR_AFASP_LSB       0
`define AVIFR_NUS_MSB         1
`define AVIFR_NUS_LSB         0
`define AVIFR_VFC_MSB         6
`define AVIFR_VFC_LSB         0
`define AVIFR_PRC_MSB         3
`define AVIFR_PRC_LSB         0
`define AVIFR_FLAG_AVI_BIT    0
`define AVIFR_FLAG_WIDTH      7

// Reset values
`define AVIFR_FIELD_RST       8'h00
`define AVIFR_FLAG_RST        7'h00
`define AVIFR_IRQ_RST         2'h0

// Interrupt status bits
`define AVIFR_IRQ_FRAME_BIT   0
`define AVIFR_IRQ_CHANGE_BIT  1

`endif

// File: rtl/avifr_field_reg.v
`timescale 1ns/1ps
`default_nettype none
`include "avifr_defines.vh"

// One read-only field register loaded from the frame parser
module avifr_field_reg #(
  parameter WIDTH = 8
) (
  input  wire             clk_i,
  input  wire             rst_i,
  input  wire             load_i,
  input  wire [WIDTH-1:0] data_i,
  output reg  [WIDTH-1:0] q_o,
  output reg              changed_o
);
  always @(posedge clk_i) begin
    if (rst_i) begin
      q_o       <= {WIDTH{1'b0}};
      changed_o <= 1'b0;
    end else begin
      changed_o <= load_i && (data_i != q_o);
      if (load_i) begin
        q_o <= data_i;
      end
    end
  end
endmodule // avifr_field_reg

`default_nettype wire

// File: verification/avifr_readout_checker.sv
`timescale 1ns/1ps
`default_nettype none
module avifr_readout_checker (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        wb_err_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic req;
  logic rd;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  // Master still holds address in the answer cycle
  assign rd = wb_ack_o && !wb_we_i;
  a_answer_next: assert property (req |=> wb_ack_o ^ wb_err_o)
    else $error("no single answer");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_err_unmapped: assert property (req && wb_adr_i == 8'h90 |=>
    wb_err_o) else $error("no error");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("data outside ack");
  a_fmt_bits: assert property (rd && wb_adr_i == 8'h81 |->
    wb_dat_o[31:7] == 25'h0 && !wb_dat_o[4]) else $error("0x81 spare bits");
  a_scale_bits: assert property (rd && wb_adr_i == 8'h83 |->
    wb_dat_o[31:2] == 30'h0) else $error("0x83 spare bits");
  a_vfc_bits: assert property (rd && wb_adr_i == 8'h84 |->
    wb_dat_o[31:7] == 25'h0) else $error("0x84 spare bits");
  a_rep_bits: assert property (rd && wb_adr_i == 8'h85 |->
    wb_dat_o[31:4] == 28'h0) else $error("0x85 spare bits");
  a_flag_bits: assert property (rd && wb_adr_i == 8'h87 |->
    wb_dat_o[31:7] == 25'h0) else $error("0x87 spare bits");
endmodule // avifr_readout_checker
bind avifr_readout avifr_readout_checker u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .wb_err_o(wb_err_o));
`default_nettype wire

// File: verification/avi_infoframe_field_readout_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module avi_infoframe_field_readout_tb_top;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        fv = 1'b0;
  logic [1:0]  cf = 2'h0, bar = 2'h0, scan = 2'h0, col = 2'h0;
  logic [1:0]  pa = 2'h0, nus = 2'h0;
  logic [3:0]  aa = 4'h0, prc = 4'h0, sel = 4'h1;
  logic [6:0]  vfc = 7'h00;
  logic [5:0]  oc = 6'h00;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, err, irq, re;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, rd;
  int          failures = 0;
  int          checks_done = 0;

  initial forever #25 clk_i = ~clk_i;

  avifr_readout dut (.clk_i(clk_i), .rst_i(rst_i), .frame_valid_i(fv),
    .colour_format_i(cf), .bar_info_i(bar), .scan_info_i(scan),
    .colorimetry_i(col), .picture_aspect_i(pa), .active_aspect_i(aa),
    .nonuniform_scaling_code_i(nus), .video_format_code_i(vfc),
    .pixel_repetition_count_i(prc), .other_change_i(oc), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
    .irq_o(irq));

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: %h vs %h", $time, seen, exp);
    end
  endtask

  task finish_test;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Hold the request until ack or err is sampled high at an edge
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while ((ack | err) !== 1'b1 && n < 20);
    if ((ack | err) !== 1'b1) begin
      failures++;
      finish_test;
    end else begin
      rd = rdat;
      re = err;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
    end
  endtask

  task frame(input logic [1:0] i);
    @(posedge clk_i);
    fv   <= 1'b1;
    cf   <= i;
    bar  <= i;
    scan <= i;
    col  <= i;
    pa   <= i;
    nus  <= i;
    aa   <= {2'b10, i};
    vfc  <= {5'h10, i};
    prc  <= {2'b00, i};
    @(posedge clk_i);
    fv <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask

  task test_fields;
    for (int i = 0; i < 4; i++) begin
      frame(i[1:0]);
      bus(1'b0, 8'h81, 32'h0);
      check(rd, {25'h0, i[1:0], 1'b0, i[1:0], i[1:0]});
      bus(1'b0, 8'h82, 32'h0);
      check(rd, {24'h0, i[1:0], i[1:0], 2'b10, i[1:0]});
      bus(1'b0, 8'h83, 32'h0);
      check(rd, {30'h0, i[1:0]});
      bus(1'b0, 8'h84, 32'h0);
      check(rd, {25'h0, 5'h10, i[1:0]});
      bus(1'b0, 8'h85, 32'h0);
      check(rd, {30'h0, i[1:0]});
    end
    $display("fields done");
  endtask

  task test_flags;
    bus(1'b0, 8'h87, 32'h0);
    frame(2'd1);
    bus(1'b0, 8'h8F, 32'h0);
    check(rd, 32'h1);
    bus(1'b0, 8'h87, 32'h0);
    check(rd, 32'h0);
    frame(2'd1);
    bus(1'b0, 8'h87, 32'h0);
    check(rd, 32'h0);
    @(posedge clk_i);
    oc <= 6'h20;
    @(posedge clk_i);
    oc <= 6'h00;
    bus(1'b0, 8'h87, 32'h0);
    check(rd, 32'h40);
    $display("flags done");
  endtask

  task test_ro;
    bus(1'b1, 8'h84, 32'h000000FF);
    bus(1'b0, 8'h84, 32'h0);
    check(rd, 32'h41);
    bus(1'b0, 8'h90, 32'h0);
    check({31'h0, re}, 32'h1);
    $display("read-only done");
  endtask

  task test_irq;
    bus(1'b1, 8'hF0, 32'h3);
    frame(2'd2);
    @(negedge clk_i);
    check({31'h0, irq}, 32'h0);
    bus(1'b0, 8'hF0, 32'h0);
    check(rd, 32'h3);
    bus(1'b1, 8'hF4, 32'h1);
    repeat (2) @(negedge clk_i);
    check({31'h0, irq}, 32'h1);
    bus(1'b1, 8'hF0, 32'h1);
    repeat (2) @(negedge clk_i);
    check({31'h0, irq}, 32'h0);
    $display("irq done");
  endtask

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    test_fields;
    test_flags;
    test_ro;
    test_irq;
    finish_test;
  end
endmodule // avi_infoframe_field_readout_tb_top
`default_nettype wire
